/* verilog/tc_cfg_pkg.sv */
package tc_cfg_pkg;
    // Register pointers on the serial register port
    localparam logic [7:0] PTR_STATUS = 8'h20;
    localparam logic [7:0] PTR_SENSOR = 8'h21;
    localparam logic [7:0] PTR_DEVICE = 8'h22;
    // Reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] SENSOR_RST = 8'h00;
    localparam logic [7:0] DEVICE_RST = 8'h00;
    // Status field positions
    localparam int ST_BURST_BIT = 7;
    localparam int ST_UPDATE_BIT = 6;
    localparam int ST_SHORT_BIT = 5;
    localparam int ST_RANGE_BIT = 4;
    // Sensor configuration fields, implemented bits only
    localparam logic [7:0] SENSOR_MASK = 8'h77;
    localparam int SENS_TYPE_LSB = 4;
    localparam int SENS_FILT_LSB = 0;
    // Device configuration fields
    localparam int DEV_CJRES_BIT = 7;
    localparam int DEV_ADCRES_LSB = 5;
    localparam int DEV_BURST_LSB = 2;
    localparam int DEV_MODE_LSB = 0;
    // Power modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SHDN = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h3;
    // Filter arithmetic
    localparam int FRAC_BITS = 4;
    localparam int FILT_W = 20;
    localparam int DIV_NUM_W = 32;
    localparam int DIV_DEN_W = 8;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    // Coarse cold-junction step clears the two lowest bits
    localparam logic [15:0] CJ_COARSE_MASK = 16'hFFFC;

    // Measurement sequencer states
    typedef enum logic [4:0] {
        SEQ_IDLE = 5'b00001,
        SEQ_CONV = 5'b00010,
        SEQ_FILT = 5'b00100,
        SEQ_STORE = 5'b01000,
        SEQ_ALERT = 5'b10000
    } seq_state_t;

    // Samples per burst, two to the power of the code
    function automatic logic [7:0] burst_samples(input logic [2:0] code);
        burst_samples = 8'h01 << code;
    endfunction

    // Signed strictly-greater compare of two temperatures
    function automatic logic temp_above(input logic [15:0] t, input logic [15:0] lim);
        temp_above = $signed(t) > $signed(lim);
    endfunction
endpackage

/* verilog/tc_div_if.sv */
`timescale 1ns/1ns
interface tc_div_if;
    logic start;
    logic [31:0] num;
    logic [7:0] den;
    logic done;
    logic [31:0] quot;
    modport client(output start, output num, output den, input done, input quot);
    modport server(input start, input num, input den, output done, output quot);
endinterface // tc_div_if

/* verilog/tc_divider.sv */
`timescale 1ns/1ns
module tc_divider (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Divide request and answer
    tc_div_if.server div_bus
);
    logic [5:0] steps;
    logic [31:0] quo;
    logic [7:0] rem;
    logic [8:0] trial;

    // Next partial remainder
    assign trial = {rem, quo[31]};
    assign div_bus.quot = quo;

    // Restoring divider, one quotient bit per cycle
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            steps <= 6'h00;
            quo <= 32'h0000_0000;
            rem <= 8'h00;
            div_bus.done <= 1'b0;
        end else begin
            div_bus.done <= 1'b0;
            if (div_bus.start) begin
                steps <= tc_cfg_pkg::DIV_STEPS;
                quo <= div_bus.num;
                rem <= 8'h00;
            end else if (steps != 6'h00) begin
                steps <= steps - 6'h01;
                if (trial >= {1'b0, div_bus.den}) begin
                    rem <= 8'(trial - {1'b0, div_bus.den});
                    quo <= {quo[30:0], 1'b1};
                end else begin
                    rem <= trial[7:0];
                    quo <= {quo[30:0], 1'b0};
                end
                div_bus.done <= (steps == 6'h01);
            end
        end
    end
endmodule // tc_divider

/* verilog/tc_alert_compare.sv */
`timescale 1ns/1ns
module tc_alert_compare (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Temperatures and limits
    input wire logic [15:0] hot_i,
    input wire logic [15:0] cold_i,
    input wire logic [3:0][15:0] limit_i,
    input wire logic [3:0] cold_sel_i,
    // Comparison result
    output logic [3:0] hit_o
);
    // One comparison per alert on the stored, already filtered result
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hit_o <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                hit_o[i] <= tc_cfg_pkg::temp_above(cold_sel_i[i] ? cold_i : hot_i, // RL23
                                                   limit_i[i]); // RL8 RL21
            end
        end
    end
endmodule // tc_alert_compare

/* verilog/thermocouple_status_config.sv */
`timescale 1ns/1ns
// Functional notes
// [RL1] Burst-done flag sets when a burst completes; host clears and polls it.
// [RL2] Update flag sets on every finished conversion; host clears and polls it.
// [RL3] Short flag reads 1 while thermocouple is shorted, else 0.
// [RL4] Range flag reads 1 when input or compensated result is out of range.
// [RL5] Input out of range: hot registers hold, cold register keeps updating.
// [RL6] Sum out of range: raw hot and cold update, compensated hot holds.
// [RL7] On fault variant the range flag also reports an open thermocouple; the code sets it from emf_err_q and sum_err_q only.
// [RL8] Alert bit is 1 when monitored temperature strictly exceeds its limit.
// [RL9] Three-bit type code selects K, J, T, N, S, E, B, R.
// [RL10] Three-bit filter code picks n; zero disables, seven is strongest.
// [RL11] Filter output is k*new + (1-k)*old with k = 2/(2^n+1).
// [RL12] Any sensor configuration write restarts the filter history.
// [RL13] Resolution changes apply from the next measurement cycle only.
// [RL14] Cold-junction resolution bit selects 0.0625 or 0.25 degree steps.
// [RL15] Two-bit code selects 18, 16, 14 or 12 bit conversion.
// [RL16] Burst sample count is two to the power of the code.
// [RL17] Mode code: normal, shutdown, burst; code three has no effect.
// [RL18] Shutdown stops conversions; registers stay accessible.
// [RL19] Burst runs the configured samples and then shuts down by itself.
// [RL20] Each burst sample is compared against the alert limits.
// [RL21] With filtering on, alerts compare the filtered value.
// [RL22] Unimplemented configuration bits read zero and ignore writes.
// [RL23] Per-alert select picks cold-junction or compensated hot temperature.
// [RL24] Burst-done sets only after last sample is stored and compared.
module thermocouple_status_config #(
    parameter bit HAS_FAULT_DETECT = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port of the serial slave
    input wire logic [7:0] reg_ptr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Converter core
    output logic conv_start_o,
    output logic [1:0] conv_adc_res_o,
    output logic conv_cold_res_o,
    output logic [2:0] conv_type_o,
    input wire logic conv_done_i,
    input wire logic [15:0] hot_comp_i,
    input wire logic [15:0] hot_raw_i,
    input wire logic [15:0] cold_i,
    input wire logic emf_range_err_i,
    input wire logic sum_range_err_i,
    input wire logic short_fault_flag_i,
    // Alert limits and monitor selects
    input wire logic [3:0][15:0] alert_limit_value_i,
    input wire logic [3:0] alert_cold_sel_i,
    // Results
    output logic [3:0] alert_hit_o,
    output logic [15:0] hot_temp_o,
    output logic [15:0] delta_temp_o,
    output logic [15:0] cold_temp_o
);
    tc_cfg_pkg::seq_state_t seq;
    logic [7:0] sensor_cfg;
    logic [7:0] device_cfg;
    logic flag_burst;
    logic flag_update;
    logic flag_short;
    logic flag_range;
    logic [7:0] burst_left;
    logic filt_fresh;
    logic [19:0] filt_y;
    logic [19:0] filt_next;
    logic filt_neg;
    logic [15:0] hot_q;
    logic [15:0] raw_q;
    logic [15:0] cold_q;
    logic emf_err_q;
    logic sum_err_q;
    logic [15:0] hot_temp;
    logic [15:0] delta_temp;
    logic [15:0] cold_temp;
    logic [3:0] alert_hit;
    logic div_start;
    logic [31:0] div_num;
    logic [7:0] div_den;
    logic wr_status;
    logic wr_sensor;
    logic wr_device;
    logic [1:0] mode;
    logic [2:0] filt_code;
    logic run_ok;
    logic accept;
    logic need_filter;
    logic last_sample;
    logic [31:0] filt_sum;
    logic [15:0] hot_store;
    logic [7:0] status_rd;

    tc_div_if div_bus();

    // Register decode and field views
    assign wr_status = reg_wr_i && (reg_ptr_i == tc_cfg_pkg::PTR_STATUS);
    assign wr_sensor = reg_wr_i && (reg_ptr_i == tc_cfg_pkg::PTR_SENSOR);
    assign wr_device = reg_wr_i && (reg_ptr_i == tc_cfg_pkg::PTR_DEVICE);
    assign mode = device_cfg[tc_cfg_pkg::DEV_MODE_LSB +: 2];
    assign filt_code = sensor_cfg[tc_cfg_pkg::SENS_FILT_LSB +: 3];

    // Sequencer conditions
    assign run_ok = (mode == tc_cfg_pkg::MODE_NORMAL)
                    || ((mode == tc_cfg_pkg::MODE_BURST) && (burst_left != 8'h00)); // RL19
    assign accept = (seq == tc_cfg_pkg::SEQ_CONV) && conv_done_i
                    && (mode != tc_cfg_pkg::MODE_SHDN);
    assign need_filter = (filt_code != 3'h0) && !filt_fresh
                         && !emf_range_err_i && !sum_range_err_i; // RL10
    assign last_sample = (mode == tc_cfg_pkg::MODE_BURST) && (burst_left == 8'h00);

    // Numerator (2^n+1)*Y = 2X + (2^n-1)*Yprev, in 16.4 fixed point
    assign filt_sum = ($signed({{12{hot_comp_i[15]}}, hot_comp_i, 4'h0}) <<< 1)
                      + $signed({24'h00_0000, 8'((8'h01 << filt_code) - 8'h01)})
                      * $signed({{12{filt_y[19]}}, filt_y}); // RL11
    assign hot_store = filt_fresh ? hot_q : filt_next[19:4]; // RL21

    // Divider hookup
    assign div_bus.start = div_start;
    assign div_bus.num = div_num;
    assign div_bus.den = div_den;

    tc_divider u_divider (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .div_bus(div_bus)
    );

    tc_alert_compare u_alert (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .hot_i(hot_temp),
        .cold_i(cold_temp),
        .limit_i(alert_limit_value_i),
        .cold_sel_i(alert_cold_sel_i),
        .hit_o(alert_hit)
    );

    // Measurement sequencer
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seq <= tc_cfg_pkg::SEQ_IDLE;
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= 1'b0;
            case (seq)
                tc_cfg_pkg::SEQ_IDLE: begin
                    if (run_ok) begin
                        conv_start_o <= 1'b1;
                        seq <= tc_cfg_pkg::SEQ_CONV;
                    end
                end
                tc_cfg_pkg::SEQ_CONV: begin
                    if (mode == tc_cfg_pkg::MODE_SHDN) begin
                        seq <= tc_cfg_pkg::SEQ_IDLE; // RL18
                    end else if (conv_done_i) begin
                        seq <= need_filter ? tc_cfg_pkg::SEQ_FILT : tc_cfg_pkg::SEQ_STORE;
                    end
                end
                tc_cfg_pkg::SEQ_FILT: begin
                    if (div_bus.done) begin
                        seq <= tc_cfg_pkg::SEQ_STORE;
                    end
                end
                tc_cfg_pkg::SEQ_STORE: begin
                    seq <= tc_cfg_pkg::SEQ_ALERT;
                end
                tc_cfg_pkg::SEQ_ALERT: begin
                    seq <= tc_cfg_pkg::SEQ_IDLE;
                end
                default: begin
                    seq <= tc_cfg_pkg::SEQ_IDLE;
                end
            endcase
        end
    end

    // Resolution and type latched at conversion start
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            conv_adc_res_o <= 2'h0;
            conv_cold_res_o <= 1'b0;
            conv_type_o <= 3'h0;
        end else if ((seq == tc_cfg_pkg::SEQ_IDLE) && run_ok) begin
            conv_adc_res_o <= device_cfg[tc_cfg_pkg::DEV_ADCRES_LSB +: 2]; // RL13 RL15
            conv_cold_res_o <= device_cfg[tc_cfg_pkg::DEV_CJRES_BIT]; // RL13
            conv_type_o <= sensor_cfg[tc_cfg_pkg::SENS_TYPE_LSB +: 3]; // RL9
        end
    end

    // Sample capture and divider launch
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hot_q <= 16'h0000;
            raw_q <= 16'h0000;
            cold_q <= 16'h0000;
            emf_err_q <= 1'b0;
            sum_err_q <= 1'b0;
            div_start <= 1'b0;
            div_num <= 32'h0000_0000;
            div_den <= 8'h00;
            filt_neg <= 1'b0;
        end else begin
            div_start <= 1'b0;
            if (accept) begin
                hot_q <= hot_comp_i;
                raw_q <= hot_raw_i;
                cold_q <= conv_cold_res_o ? (cold_i & tc_cfg_pkg::CJ_COARSE_MASK) : cold_i; // RL14
                emf_err_q <= emf_range_err_i;
                sum_err_q <= sum_range_err_i;
                div_start <= need_filter;
                filt_neg <= filt_sum[31];
                div_num <= filt_sum[31] ? 32'(-filt_sum) : filt_sum;
                div_den <= 8'((8'h01 << filt_code) + 8'h01); // RL11
            end
        end
    end

    // Filter output register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filt_next <= 20'h0_0000;
        end else if (accept && !need_filter) begin
            filt_next <= {hot_comp_i, 4'h0}; // RL10
        end else if ((seq == tc_cfg_pkg::SEQ_FILT) && div_bus.done) begin
            filt_next <= filt_neg ? 20'(-div_bus.quot) : div_bus.quot[19:0]; // RL11
        end
    end

    // Filter history, restarted by a sensor configuration write
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            filt_fresh <= 1'b1;
            filt_y <= 20'h0_0000;
        end else if (wr_sensor) begin
            filt_fresh <= 1'b1; // RL12
        end else if ((seq == tc_cfg_pkg::SEQ_STORE) && !emf_err_q && !sum_err_q) begin
            filt_fresh <= 1'b0;
            filt_y <= filt_fresh ? {hot_q, 4'h0} : filt_next;
        end
    end

    // Result registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hot_temp <= 16'h0000;
            delta_temp <= 16'h0000;
            cold_temp <= 16'h0000;
            flag_range <= 1'b0;
        end else if (seq == tc_cfg_pkg::SEQ_STORE) begin
            cold_temp <= cold_q; // RL5
            if (!emf_err_q) begin
                delta_temp <= raw_q; // RL6
            end
            if (!emf_err_q && !sum_err_q) begin
                hot_temp <= hot_store; // RL5 RL6
            end
            flag_range <= emf_err_q || sum_err_q; // RL4 RL7
        end
    end

    // Event flags: burst and update are sticky, a set beats a clear in the same cycle; short follows its input
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_burst <= 1'b0;
            flag_update <= 1'b0;
            flag_short <= 1'b0;
        end else begin
            flag_short <= HAS_FAULT_DETECT && short_fault_flag_i; // RL3
            if ((seq == tc_cfg_pkg::SEQ_ALERT) && last_sample) begin
                flag_burst <= 1'b1; // RL1 RL24
            end else if (wr_status && reg_wdata_i[tc_cfg_pkg::ST_BURST_BIT]) begin
                flag_burst <= 1'b0; // RL1
            end
            if (seq == tc_cfg_pkg::SEQ_ALERT) begin
                flag_update <= 1'b1; // RL2
            end else if (wr_status && reg_wdata_i[tc_cfg_pkg::ST_UPDATE_BIT]) begin
                flag_update <= 1'b0; // RL2
            end
        end
    end

    // Sensor configuration register
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sensor_cfg <= tc_cfg_pkg::SENSOR_RST;
        end else if (wr_sensor) begin
            sensor_cfg <= reg_wdata_i & tc_cfg_pkg::SENSOR_MASK; // RL9 RL10 RL22
        end
    end

    // Device configuration and burst countdown
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            device_cfg <= tc_cfg_pkg::DEVICE_RST;
            burst_left <= 8'h00;
        end else if (wr_device) begin
            device_cfg[7:2] <= reg_wdata_i[7:2];
            if (reg_wdata_i[1:0] != tc_cfg_pkg::MODE_NONE) begin
                device_cfg[1:0] <= reg_wdata_i[1:0]; // RL17
            end
            if (reg_wdata_i[1:0] == tc_cfg_pkg::MODE_BURST) begin
                burst_left <= tc_cfg_pkg::burst_samples(reg_wdata_i[4:2]); // RL16
            end
        end else if ((seq == tc_cfg_pkg::SEQ_STORE) && (mode == tc_cfg_pkg::MODE_BURST)) begin
            burst_left <= burst_left - 8'h01; // RL20
        end else if ((seq == tc_cfg_pkg::SEQ_ALERT) && last_sample) begin
            device_cfg[1:0] <= tc_cfg_pkg::MODE_SHDN; // RL19
        end
    end

    // Status byte as read
    always_comb begin
        status_rd = tc_cfg_pkg::STATUS_RST;
        status_rd[tc_cfg_pkg::ST_BURST_BIT] = flag_burst;
        status_rd[tc_cfg_pkg::ST_UPDATE_BIT] = flag_update;
        status_rd[tc_cfg_pkg::ST_SHORT_BIT] = flag_short;
        status_rd[tc_cfg_pkg::ST_RANGE_BIT] = flag_range;
        status_rd[3:0] = alert_hit; // RL8
    end

    // Read data, answered one cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_ptr_i)
                tc_cfg_pkg::PTR_STATUS: reg_rdata_o <= status_rd;
                tc_cfg_pkg::PTR_SENSOR: reg_rdata_o <= sensor_cfg; // RL22
                tc_cfg_pkg::PTR_DEVICE: reg_rdata_o <= device_cfg;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Result ports
    assign alert_hit_o = alert_hit;
    assign hot_temp_o = hot_temp;
    assign delta_temp_o = delta_temp;
    assign cold_temp_o = cold_temp;

    // Checks
    a_burst_done_set: assert property ( // RL1
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (seq == tc_cfg_pkg::SEQ_ALERT) && last_sample
        |=> flag_burst && (mode == tc_cfg_pkg::MODE_SHDN || $past(wr_device)))
        else $error("burst end did not set flag and shut down");
    a_update_flag_set: assert property ( // RL2
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (seq == tc_cfg_pkg::SEQ_STORE) ##1 1'b1 |=> flag_update)
        else $error("update flag not set after conversion");
    a_short_flag_follow: assert property ( // RL3
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ##1 (flag_short == (HAS_FAULT_DETECT && $past(short_fault_flag_i))))
        else $error("short flag does not follow fault");
    a_emf_hold: assert property ( // RL5
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (seq == tc_cfg_pkg::SEQ_STORE) && emf_err_q
        |=> $stable(hot_temp) && $stable(delta_temp) && (cold_temp == $past(cold_q)))
        else $error("hot result changed on input range error");
    a_sum_hold: assert property ( // RL6
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (seq == tc_cfg_pkg::SEQ_STORE) && !emf_err_q && sum_err_q
        |=> $stable(hot_temp) && (delta_temp == $past(raw_q)) && flag_range)
        else $error("compensated result changed on sum range error");
    a_filter_restart: assert property ( // RL12
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_sensor |=> filt_fresh ##1 (!div_start))
        else $error("filter history survived configuration write");
    a_res_held: assert property ( // RL13
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (seq == tc_cfg_pkg::SEQ_CONV) && $past(seq == tc_cfg_pkg::SEQ_CONV)
        |-> $stable(conv_adc_res_o) && $stable(conv_cold_res_o))
        else $error("resolution changed during a measurement");
    a_mode_none: assert property ( // RL17
        @(posedge sys_clk_i) disable iff (!nrst_i)
        wr_device && (reg_wdata_i[1:0] == tc_cfg_pkg::MODE_NONE)
        && !((seq == tc_cfg_pkg::SEQ_ALERT) && last_sample)
        |=> mode == $past(mode))
        else $error("mode code three changed the mode");
    a_shutdown_quiet: assert property ( // RL18
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (mode == tc_cfg_pkg::MODE_SHDN) && (seq == tc_cfg_pkg::SEQ_IDLE)
        |=> !conv_start_o)
        else $error("conversion started in shutdown");
    a_unimpl_zero: assert property ( // RL22
        @(posedge sys_clk_i) disable iff (!nrst_i)
        reg_rd_i && (reg_ptr_i == tc_cfg_pkg::PTR_SENSOR)
        |=> (reg_rdata_o[7] == 1'b0) && (reg_rdata_o[3] == 1'b0))
        else $error("unimplemented sensor bits read nonzero");
endmodule // thermocouple_status_config

/* bench/conv_model.sv */
`timescale 1ns/1ns
// Converter core stand-in, answers each start after a fixed delay
module conv_model #(
    parameter int DLY = 20
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Start and done
    input wire logic start_i,
    output logic done_o,
    output int starts_o
);
    int cnt;
    // Delay count, one done pulse per start
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= 0;
            done_o <= 1'b0;
            starts_o <= 0;
        end else begin
            done_o <= (cnt == 1);
            if (start_i) begin
                cnt <= DLY;
                starts_o <= starts_o + 1;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // conv_model

/* bench/thermocouple_status_config_tb.sv */
`timescale 1ns/1ns
module thermocouple_status_config_tb;
    localparam logic [7:0] ST = tc_cfg_pkg::PTR_STATUS;
    localparam logic [7:0] SE = tc_cfg_pkg::PTR_SENSOR;
    localparam logic [7:0] DE = tc_cfg_pkg::PTR_DEVICE;
    logic clk, nrst, wr_s, rd_s, start, cres, done, emf, sum, shortf;
    logic [7:0] ptr, wd, rdata;
    logic [1:0] ares;
    logic [2:0] ty;
    logic [15:0] hot, raw, cold, ht, dt, ct;
    logic [3:0][15:0] lim;
    logic [3:0] sel, hit;
    int starts, s0, error_cnt = 0, check_count = 0;
    thermocouple_status_config uut (.sys_clk_i(clk), .nrst_i(nrst), .reg_ptr_i(ptr),
        .reg_wr_i(wr_s), .reg_wdata_i(wd), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .conv_start_o(start), .conv_adc_res_o(ares), .conv_cold_res_o(cres),
        .conv_type_o(ty), .conv_done_i(done), .hot_comp_i(hot), .hot_raw_i(raw),
        .cold_i(cold), .emf_range_err_i(emf), .sum_range_err_i(sum),
        .short_fault_flag_i(shortf), .alert_limit_value_i(lim), .alert_cold_sel_i(sel),
        .alert_hit_o(hit), .hot_temp_o(ht), .delta_temp_o(dt), .cold_temp_o(ct));
    conv_model #(.DLY(20)) core (.sys_clk_i(clk), .nrst_i(nrst), .start_i(start),
        .done_o(done), .starts_o(starts));
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(negedge clk);
        ptr = p;
        wd = d;
        wr_s = 1'b1;
        @(negedge clk);
        wr_s = 1'b0;
    endtask
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        @(negedge clk);
        ptr = p;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rdc(input logic [7:0] p, input logic [7:0] e, input string nm);
        logic [7:0] d;
        rd(p, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask
    // Bounded poll of one status bit
    task automatic poll(input int b);
        logic [7:0] d;
        d = 8'h00;
        for (int i = 0; i < 80 && d[b] !== 1'b1; i++) rd(ST, d);
        if (d[b] !== 1'b1) begin
            error_cnt++;
            $display("BAD status bit %0d exp 1 got %b", b, d[b]);
            stop_test();
        end
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Main sequence
    initial begin
        {nrst, wr_s, rd_s, emf, sum, shortf} = 6'h00;
        {ptr, wd} = 16'h0000;
        {hot, raw, cold} = {16'h0100, 16'h0123, 16'h0053};
        sel = 4'b0100;
        lim = {16'h7FFF, 16'h004F, 16'h0100, 16'h00FF};
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        rdc(ST, 8'h00, "status");
        rdc(SE, 8'h00, "sensor");
        rdc(DE, 8'h00, "device");
        $display("test reset done");
        wr(DE, 8'h01);
        wr(SE, 8'hFF);
        rdc(SE, 8'h77, "sensor");
        wr(DE, 8'hE7);
        rdc(DE, 8'hE5, "device");
        rdc(8'h30, 8'h00, "unmapped");
        wr(ST, 8'hC0);
        shortf = 1'b1;
        s0 = starts;
        repeat (100) @(negedge clk);
        rdc(ST, 8'h20, "status");
        chk("starts", 16'(s0), 16'(starts));
        shortf = 1'b0;
        $display("test shutdown done");
        wr(SE, 8'h00);
        wr(DE, 8'h80);
        poll(6);
        chk("hot", 16'h0100, ht);
        chk("delta", 16'h0123, dt);
        chk("cold", 16'h0050, ct);
        chk("cold res", 16'h0001, {15'h0000, cres});
        chk("hit", 16'h0005, {12'h000, hit});
        {emf, hot, raw, cold} = {1'b1, 16'h0200, 16'h0222, 16'h0063};
        wr(ST, 8'hC0);
        poll(6);
        chk("hot", 16'h0100, ht);
        chk("delta", 16'h0123, dt);
        chk("cold", 16'h0060, ct);
        rdc(ST, 8'h55, "status");
        {emf, sum} = 2'b01;
        wr(ST, 8'hC0);
        poll(6);
        chk("hot", 16'h0100, ht);
        chk("delta", 16'h0222, dt);
        $display("test range done");
        {sum, hot} = {1'b0, 16'h0000};
        wr(DE, 8'h01);
        wr(ST, 8'hC0);
        s0 = starts;
        wr(DE, 8'h06);
        poll(7);
        rdc(DE, 8'h05, "device");
        chk("starts", 16'(s0 + 2), 16'(starts));
        chk("hit", 16'h0004, {12'h000, hit});
        $display("test burst done");
        wr(SE, 8'h31);
        hot = 16'h0300;
        wr(ST, 8'hC0);
        wr(DE, 8'h42);
        poll(7);
        {hot, lim[0]} = {16'h0600, 16'h0550};
        wr(ST, 8'hC0);
        wr(DE, 8'h42);
        poll(7);
        chk("hot", 16'h0500, ht);
        chk("hit", 16'h0006, {12'h000, hit});
        chk("type", 16'h0003, {13'h0000, ty});
        chk("adc res", 16'h0002, {14'h0000, ares});
        $display("test filter done");
        stop_test();
    end
endmodule // thermocouple_status_config_tb
